// ### rtl/pfs_persist.sv
// Counts cycles that a condition holds continuously; flags at a limit.
// Assumes cond is a synchronous level; srst or a low cond restarts the count.
`timescale 1ns/100ps
module pfs_persist #(
  parameter int LIMIT = 1
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic cond,
  output logic      hit
);
  import pfs_pkg::*;
  logic [CNT_W-1:0] count;
  always_ff @(posedge sys_clk) begin
    if (srst || !cond) begin
      count <= '0;
      hit   <= 1'b0;
    end else if (count >= CNT_W'(LIMIT - 1)) begin
      hit <= 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule // pfs_persist

// ### rtl/pfs_pkg.sv
// Constants and states for the PWM fault supervisor.
// Assumes a 25 MHz system clock and a synchronous active-high reset.
package pfs_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int FAULT_FILTER_US = 10;
  localparam int LATCH_COUNT_CYC = 4;
  localparam int OTP_BLANK_MS = 8;
  localparam int OVERLOAD_MS = 15;
  localparam int AUTOREC_MS = 1000;
  localparam int SUPPLY_OV_BLANK_US = 10;
  localparam int LINE_OV_BLANK_US = 20;
  localparam int BROWNOUT_MS = 50;
  localparam int FAULT_FILTER_CYC = FAULT_FILTER_US * (CLK_HZ / 1000000);
  localparam int SUPPLY_OV_CYC = SUPPLY_OV_BLANK_US * (CLK_HZ / 1000000);
  localparam int LINE_OV_CYC = LINE_OV_BLANK_US * (CLK_HZ / 1000000);
  localparam int OTP_BLANK_CYC = OTP_BLANK_MS * (CLK_HZ / 1000);
  localparam int OVERLOAD_CYC = OVERLOAD_MS * (CLK_HZ / 1000);
  localparam int AUTOREC_CYC = AUTOREC_MS * (CLK_HZ / 1000);
  localparam int BROWNOUT_CYC = BROWNOUT_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 25;
  localparam int LATCH_W = 3;
  typedef enum logic [2:0] {
    PFS_OFF, PFS_WAIT_START, PFS_RUN, PFS_RECOVER, PFS_LATCHED, PFS_BROWN
  } pfs_state_t;
endpackage

// ### rtl/pfs_supervisor.sv
// Protection and sequencing core of the PWM fault supervisor.
// Assumes comparator pins are asynchronous and sw_clk_tick marks each
// switching cycle start as a one-cycle pulse in the sys_clk domain.
`timescale 1ns/100ps
module pfs_supervisor #(
  parameter bit AUTO_RECOVER_SHORT = 1'b1,
  parameter int OTP_BLANK_CYCLES   = pfs_pkg::OTP_BLANK_CYC,
  parameter int OVERLOAD_CYCLES    = pfs_pkg::OVERLOAD_CYC,
  parameter int AUTOREC_CYCLES     = pfs_pkg::AUTOREC_CYC,
  parameter int BROWNOUT_CYCLES    = pfs_pkg::BROWNOUT_CYC
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic sw_clk_tick,
  input  wire logic fault_pin_upper_level,
  input  wire logic fault_pin_low,
  input  wire logic supply_overvoltage_level,
  input  wire logic current_limit,
  input  wire logic line_ok,
  input  wire logic line_low,
  input  wire logic line_guard_enable_level,
  input  wire logic line_overvoltage_level,
  input  wire logic line_high,
  input  wire logic feedback_skip,
  input  wire logic supply_start,
  input  wire logic supply_min,
  input  wire logic supply_low,
  output logic      drive_enable,
  output logic      soft_start_ground,
  output logic      ntc_boost_bias,
  output logic      startup_source_on,
  output logic      jitter_enable,
  output logic      overload_flag,
  output logic      fault_latched
);
  import pfs_pkg::*;

  logic fp_hi;
  logic fp_lo;
  logic vcc_over;
  logic ilim;
  logic line_on;
  logic line_off;
  logic guard_lvl;
  logic line_over;
  logic hi_line;
  logic skip;
  logic vcc_on;
  logic vcc_min;
  logic vcc_low;

  // Comparator levels pass two flops before any logic reads them
  pfs_sync u_s0 (.sys_clk(sys_clk), .srst(srst),
    .async_in(fault_pin_upper_level),
    .sync_out(fp_hi));
  pfs_sync u_s1 (.sys_clk(sys_clk), .srst(srst),
    .async_in(fault_pin_low),
    .sync_out(fp_lo));
  pfs_sync u_s2 (.sys_clk(sys_clk), .srst(srst),
    .async_in(supply_overvoltage_level),
    .sync_out(vcc_over));
  pfs_sync u_s3 (.sys_clk(sys_clk), .srst(srst),
    .async_in(current_limit),
    .sync_out(ilim));
  pfs_sync u_s4 (.sys_clk(sys_clk), .srst(srst),
    .async_in(line_ok),
    .sync_out(line_on));
  pfs_sync u_s5 (.sys_clk(sys_clk), .srst(srst),
    .async_in(line_low),
    .sync_out(line_off));
  pfs_sync u_s6 (.sys_clk(sys_clk), .srst(srst),
    .async_in(line_guard_enable_level),
    .sync_out(guard_lvl));
  pfs_sync u_s7 (.sys_clk(sys_clk), .srst(srst),
    .async_in(line_overvoltage_level),
    .sync_out(line_over));
  pfs_sync u_s8 (.sys_clk(sys_clk), .srst(srst),
    .async_in(line_high),
    .sync_out(hi_line));
  pfs_sync u_s9 (.sys_clk(sys_clk), .srst(srst),
    .async_in(feedback_skip),
    .sync_out(skip));
  pfs_sync u_s10 (.sys_clk(sys_clk), .srst(srst),
    .async_in(supply_start),
    .sync_out(vcc_on));
  pfs_sync u_s11 (.sys_clk(sys_clk), .srst(srst),
    .async_in(supply_min),
    .sync_out(vcc_min));
  pfs_sync u_s12 (.sys_clk(sys_clk), .srst(srst),
    .async_in(supply_low),
    .sync_out(vcc_low));

  pfs_state_t       state;
  logic             vcc_min_d;
  logic             guard_en;
  logic             guard_sampled;
  logic             otp_blank;
  logic [CNT_W-1:0] otp_cnt;
  logic             fault_cond;
  logic             filt_done;
  logic [LATCH_W-1:0] latch_cnt;
  logic             latch_confirm;
  logic             vcc_over_hit;
  logic             line_over_hit;
  logic             line_off_hit;
  logic             brownout;
  logic             ilim_seen;
  logic [CNT_W-1:0] ovl_cnt;
  logic             ovl_valid;
  logic [CNT_W-1:0] rec_cnt;
  logic             rec_done;
  logic             general_reset;

  // Brown-out sampling of the enable level at supply minimum
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      vcc_min_d     <= 1'b0;
      guard_en      <= 1'b1;
      guard_sampled <= 1'b0;
    end else begin
      vcc_min_d <= vcc_min;
      if (vcc_min && !vcc_min_d && !guard_sampled) begin
        guard_en      <= guard_lvl;
        guard_sampled <= 1'b1;
      end
    end
  end

  // Thermal blanking window from each start-up
  always_ff @(posedge sys_clk) begin
    if (srst || state == PFS_WAIT_START) begin
      otp_cnt   <= '0;
      otp_blank <= 1'b1;
    end else if (otp_blank) begin
      if (otp_cnt >= CNT_W'(OTP_BLANK_CYCLES - 1))
        otp_blank <= 1'b0;
      else
        otp_cnt <= otp_cnt + 1'b1;
    end
  end
  assign ntc_boost_bias = otp_blank && state != PFS_OFF;

  assign fault_cond = fp_hi || (fp_lo && !otp_blank);

  // Fault-pin filter ahead of the switching-cycle count
  pfs_persist #(.LIMIT(FAULT_FILTER_CYC)) u_ffilt (
    .sys_clk(sys_clk), .srst(srst),
    .cond(fault_cond), .hit(filt_done));

  // Switching-cycle confirmation after the filter
  always_ff @(posedge sys_clk) begin
    if (srst || !filt_done) begin
      latch_cnt     <= '0;
      latch_confirm <= 1'b0;
    end else if (sw_clk_tick) begin
      if (latch_cnt >= LATCH_W'(LATCH_COUNT_CYC - 1))
        latch_confirm <= 1'b1;
      else
        latch_cnt <= latch_cnt + 1'b1;
    end
  end

  // Over-voltage blanking and brown-out filter timers
  pfs_persist #(.LIMIT(SUPPLY_OV_CYC)) u_vover (
    .sys_clk(sys_clk), .srst(srst),
    .cond(vcc_over), .hit(vcc_over_hit));
  pfs_persist #(.LIMIT(LINE_OV_CYC)) u_lover (
    .sys_clk(sys_clk), .srst(srst),
    .cond(line_over && guard_en), .hit(line_over_hit));
  pfs_persist #(.LIMIT(BROWNOUT_CYCLES)) u_loff (
    .sys_clk(sys_clk), .srst(srst),
    .cond(line_off && guard_en), .hit(line_off_hit));

  // Brown-out declared and held until the line returns
  always_ff @(posedge sys_clk) begin
    if (srst || !guard_en)
      brownout <= 1'b0;
    else if (line_off_hit)
      brownout <= 1'b1;
    else if (line_on)
      brownout <= 1'b0;
  end
  assign general_reset = state == PFS_BROWN && !brownout;

  // Overload timer, cleared by a cycle without a current-limit trip
  always_ff @(posedge sys_clk) begin
    if (srst || state != PFS_RUN) begin
      ilim_seen     <= 1'b0;
      overload_flag <= 1'b0;
      ovl_cnt       <= '0;
      ovl_valid     <= 1'b0;
    end else begin
      if (ilim) begin
        overload_flag <= 1'b1;
        ilim_seen     <= 1'b1;
      end else if (sw_clk_tick) begin
        ilim_seen <= 1'b0;
      end
      if (sw_clk_tick && !ilim_seen && !ilim) begin
        ovl_cnt       <= '0;
        overload_flag <= 1'b0;
      end else if (overload_flag) begin
        if (ovl_cnt >= CNT_W'(OVERLOAD_CYCLES - 1))
          ovl_valid <= 1'b1;
        else
          ovl_cnt <= ovl_cnt + 1'b1;
      end
    end
  end

  // Auto-recovery off timer
  always_ff @(posedge sys_clk) begin
    if (srst || state != PFS_RECOVER) begin
      rec_cnt  <= '0;
      rec_done <= 1'b0;
    end else if (rec_cnt >= CNT_W'(AUTOREC_CYCLES - 1)) begin
      rec_done <= 1'b1;
    end else begin
      rec_cnt <= rec_cnt + 1'b1;
    end
  end

  // Sequencing state machine
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= PFS_OFF;
    end else if (brownout && state != PFS_LATCHED) begin
      state <= PFS_BROWN;
    end else begin
      unique case (state)
        PFS_OFF: begin
          if (vcc_on)
            state <= PFS_WAIT_START;
        end
        PFS_WAIT_START: begin
          state <= PFS_RUN;
        end
        PFS_RUN: begin
          if (latch_confirm)
            state <= PFS_LATCHED;
          else if (vcc_over_hit)
            state <= PFS_RECOVER;
          else if (ovl_valid)
            state <= AUTO_RECOVER_SHORT ? PFS_RECOVER : PFS_LATCHED;
        end
        PFS_RECOVER: begin
          if (rec_done)
            state <= PFS_OFF;
        end
        PFS_LATCHED: begin
          if (brownout)
            state <= PFS_BROWN;
        end
        PFS_BROWN: begin
          if (general_reset)
            state <= PFS_OFF;
        end
        default: begin
          state <= PFS_OFF;
        end
      endcase
    end
  end

  // Latched-off indication, kept through a brown-out until its general reset
  always_ff @(posedge sys_clk) begin
    if (srst)
      fault_latched <= 1'b0;
    else if (state == PFS_LATCHED)
      fault_latched <= 1'b1;
    else if (general_reset)
      fault_latched <= 1'b0;
  end

  // Gate drive enable
  always_ff @(posedge sys_clk) begin
    if (srst)
      drive_enable <= 1'b0;
    else
      drive_enable <= state == PFS_RUN && !latch_confirm
        && !vcc_over
        && !ovl_valid && !brownout
        && !skip
        && !line_over_hit;
  end

  // Soft-start node held at ground outside normal running
  always_ff @(posedge sys_clk) begin
    if (srst)
      soft_start_ground <= 1'b1;
    else
      soft_start_ground <= state != PFS_RUN || brownout;
  end

  // Start-up current source keeps the controller powered
  always_ff @(posedge sys_clk) begin
    if (srst)
      startup_source_on <= 1'b1;
    else
      startup_source_on <= vcc_low || state == PFS_OFF;
  end

  // Frequency jitter only while running at high line
  always_ff @(posedge sys_clk) begin
    if (srst)
      jitter_enable <= 1'b0;
    else
      jitter_enable <= hi_line && state == PFS_RUN;
  end
endmodule // pfs_supervisor

// ### rtl/pfs_sync.sv
// Two-stage synchroniser for an asynchronous comparator level.
// Assumes the input may change at any time relative to sys_clk.
`timescale 1ns/100ps
module pfs_sync (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // pfs_sync

// ### testbench/pfs_partner.sv
// Far side model: switching tick source and gate pulse counter.
// Assumes one gate pulse per tick while drive_enable is high.
`timescale 1ns/100ps
module pfs_partner (
  input  wire logic sys_clk,
  input  wire logic drive_enable,
  output logic      sw_clk_tick,
  output int        pulses
);
  logic [2:0] div = 3'h0;
  initial pulses = 0;
  always @(posedge sys_clk) begin
    div <= div + 3'h1;
    pulses <= pulses + int'(sw_clk_tick && drive_enable);
  end
  assign sw_clk_tick = (div == 3'h7);
endmodule // pfs_partner

// ### testbench/pfs_supervisor_checker.sv
// Assertions on the supervisor top ports.
// Assumes one sys_clk domain with srst active high.
`timescale 1ns/100ps
module pfs_checker #(
  parameter int OTP_BLANK_CYCLES = 50
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic current_limit,
  input wire logic line_ok,
  input wire logic line_high,
  input wire logic feedback_skip,
  input wire logic supply_start,
  input wire logic supply_low,
  input wire logic drive_enable,
  input wire logic soft_start_ground,
  input wire logic ntc_boost_bias,
  input wire logic startup_source_on,
  input wire logic jitter_enable,
  input wire logic overload_flag,
  input wire logic fault_latched
);
  int unsigned boost_run;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  always_ff @(posedge sys_clk) begin
    if (srst || !ntc_boost_bias) boost_run <= 0;
    else boost_run <= boost_run + 1;
  end
  property p_off; fault_latched |-> !drive_enable; endproperty
  a_off: assert property (p_off) else $error("drive on");
  property p_ss; fault_latched |-> soft_start_ground; endproperty
  a_ss: assert property (p_ss) else $error("ss free");
  property p_skip; feedback_skip [*4] |-> !drive_enable; endproperty
  a_skip: assert property (p_skip) else $error("skip");
  property p_jit; (!line_high) [*4] |-> !jitter_enable; endproperty
  a_jit: assert property (p_jit) else $error("jitter");
  property p_bst; boost_run <= OTP_BLANK_CYCLES + 2; endproperty
  a_bst: assert property (p_bst) else $error("boost long");
  property p_ovl;
    (current_limit && drive_enable) [*4] |-> overload_flag;
  endproperty
  a_ovl: assert property (p_ovl) else $error("no flag");
  property p_dip; supply_low [*4] |-> startup_source_on; endproperty
  a_dip: assert property (p_dip) else $error("src off");
  property p_hold;
    fault_latched && !line_ok && !$past(line_ok) |=> fault_latched;
  endproperty
  a_hold: assert property (p_hold) else $error("unlatch");
  property p_go; $rose(drive_enable) |-> $past(supply_start, 2); endproperty
  a_go: assert property (p_go) else $error("early go");
endmodule // pfs_checker

bind pfs_supervisor pfs_checker #(
  .OTP_BLANK_CYCLES(OTP_BLANK_CYCLES)
) pfs_checker_inst (
  .sys_clk(sys_clk), .srst(srst), .current_limit(current_limit),
  .line_ok(line_ok), .line_high(line_high),
  .feedback_skip(feedback_skip), .supply_start(supply_start),
  .supply_low(supply_low), .drive_enable(drive_enable),
  .soft_start_ground(soft_start_ground),
  .ntc_boost_bias(ntc_boost_bias),
  .startup_source_on(startup_source_on),
  .jitter_enable(jitter_enable), .overload_flag(overload_flag),
  .fault_latched(fault_latched)
);

// ### testbench/pfs_supervisor_tb.sv
// Self-checking bench for the supervisor with shortened timers.
// Assumes inputs change at the falling edge of sys_clk.
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
  mismatches++; $display("BAD %0t %h %h", $time, a, b); end end
`define CY(n) repeat (n) @(negedge sys_clk)
`define WT(c, n) begin int k; k = 0; while (!(c) && k < n) begin \
  `CY(1); k++; end if (!(c)) begin mismatches++; complete_run(); end end
module pfs_supervisor_tb;
  logic sys_clk = 1'b0, srst, tick, fpu, fpl, sovp, cl, lok, llow;
  logic lgen, lovp, lhi, fbs, sst, smin, slow;
  logic de, ssg, nbb, sso, jit, ovf, fl;
  int mismatches = 0, num_checks = 0, p0, pulses;
  always #20 sys_clk = !sys_clk;
  pfs_supervisor #(.OTP_BLANK_CYCLES(50), .OVERLOAD_CYCLES(100),
    .AUTOREC_CYCLES(100), .BROWNOUT_CYCLES(100)) pfs_supervisor_inst (
    .sys_clk(sys_clk), .srst(srst), .sw_clk_tick(tick),
    .fault_pin_upper_level(fpu), .fault_pin_low(fpl),
    .supply_overvoltage_level(sovp), .current_limit(cl), .line_ok(lok),
    .line_low(llow), .line_guard_enable_level(lgen),
    .line_overvoltage_level(lovp), .line_high(lhi),
    .feedback_skip(fbs), .supply_start(sst), .supply_min(smin),
    .supply_low(slow), .drive_enable(de), .soft_start_ground(ssg),
    .ntc_boost_bias(nbb), .startup_source_on(sso),
    .jitter_enable(jit), .overload_flag(ovf), .fault_latched(fl));
  pfs_partner pfs_partner_inst (.sys_clk(sys_clk), .drive_enable(de),
    .sw_clk_tick(tick), .pulses(pulses));
  task complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task rst();
    {srst, fpu, fpl, sovp, cl, lovp, lhi, fbs, slow, smin} = 10'h200;
    {lok, llow, lgen, sst} = 4'hb;
    `CY(6);
    srst = 1'b0;
    smin = 1'b1;
    `WT(de, 20);
  endtask
  task t_start();
    `CHK(nbb, 1'b1)
    `CY(5);
    `CHK(jit, 1'b0)
    lhi = 1'b1;
    `CY(5);
    `CHK(jit, 1'b1)
    `CY(60);
    `CHK(nbb, 1'b0)
    $display("t_start done");
  endtask
  task t_clean();
    cl = 1'b1;
    `CY(5);
    `CHK(ovf, 1'b1)
    cl = 1'b0;
    `CY(30);
    `CHK(ovf, 1'b0)
    $display("t_clean done");
  endtask
  task t_skip();
    fbs = 1'b1;
    `CY(5);
    p0 = pulses;
    `CY(40);
    `CHK(pulses, p0)
    fbs = 1'b0;
    `WT(de, 10);
    $display("t_skip done");
  endtask
  task t_lovp();
    lovp = 1'b1;
    `CY(400);
    `CHK(de, 1'b1)
    `WT(!de, 150);
    lovp = 1'b0;
    `WT(de, 20);
    `CHK(fl, 1'b0)
    $display("t_lovp done");
  endtask
  task t_supply_ov();
    sovp = 1'b1;
    `CY(200);
    `CHK(de, 1'b0)
    `CHK(ssg, 1'b0)
    `WT(ssg, 80);
    sovp = 1'b0;
    `CHK(fl, 1'b0)
    `WT(de, 250);
    $display("t_supply_ov done");
  endtask
  task t_ovl();
    cl = 1'b1;
    `WT(!de, 120);
    cl = 1'b0;
    `CY(2);
    `CHK(ssg, 1'b1)
    `CY(80);
    `CHK(de, 1'b0)
    `WT(de, 80);
    `CHK(fl, 1'b0)
    $display("t_ovl done");
  endtask
  task t_brown();
    {lok, llow} = 2'h1;
    `CY(90);
    `CHK(de, 1'b1)
    `CY(20);
    `CHK(de, 1'b0)
    `CHK(ssg, 1'b1)
    sst = 1'b0;
    {lok, llow} = 2'h2;
    `CY(30);
    `CHK(de, 1'b0)
    sst = 1'b1;
    `WT(de, 20);
    $display("t_brown done");
  endtask
  task t_latch();
    fpu = 1'b1;
    `CY(200);
    `CHK(de, 1'b1)
    `WT(fl, 150);
    `CHK(de, 1'b0)
    fpu = 1'b0;
    sst = 1'b0;
    `CY(10);
    sst = 1'b1;
    `CY(20);
    `CHK(fl, 1'b1)
    {lok, llow} = 2'h1;
    `CY(120);
    `CHK(de, 1'b0)
    {lok, llow} = 2'h2;
    `WT(de, 30);
    `CHK(fl, 1'b0)
    $display("t_latch done");
  endtask
  task t_otp();
    rst();
    `CY(60);
    fpl = 1'b1;
    `WT(fl, 400);
    `CHK(de, 1'b0)
    slow = 1'b1;
    `CY(5);
    `CHK(sso, 1'b1)
    `CHK(fl, 1'b1)
    $display("t_otp done");
  endtask
  initial begin
    rst();
    t_start();
    t_clean();
    t_skip();
    t_lovp();
    t_supply_ov();
    t_ovl();
    t_brown();
    t_latch();
    t_otp();
    complete_run();
  end
endmodule // pfs_supervisor_tb
